// ---- hdl/ptm_pkg.sv ----
// package for the pwm timer block: register indexes, field positions, state record
// assumes a single 100 MHz clock and an avalon-mm master that holds requests until waitrequest is low
//
// Functional notes
// - fault enable (enable bit 6) and fault level (channel 0 control) act on all channels; polarity/clock come from each channel's own control
// - inactive state drives main and complementary outputs to the polarity level
// - a detected active fault level forces all outputs inactive and holds them there
// - clearing fault status fails while the fault input is still active
// - channel 0 period is low byte plus four high bits; period is value times pwm clock
// - zero period gives a constant output equal to the polarity level
// - channel 0 duty is low byte plus four high bits; duty is value times pwm clock
// - nonzero period at or below duty gives constant active output
// - new period, duty, polarity and clock take effect at the next period start
// - control bit 7 enables a channel interrupt only while the global enable is set
// - control bit 6 is set on period overflow and cleared only by software
// - control bit 2 picks polarity: 0 high during duty, 1 inverted
// - control bits 1-0 pick the pwm clock: oscillator over 2, 4, 8 or 16
// - enable, control, period and duty writes land only while the lock holds 55h
// - the fault input acts only when enabled; level select 0 low active, 1 high active
package ptm_pkg;
  localparam int NCH = 3;
  localparam int CNT_W = 12;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_ENABLE = 8'hcf;
  localparam logic [7:0] IDX_CTRL0 = 8'hd2;
  localparam logic [7:0] IDX_PER0_LO = 8'hd3;
  localparam logic [7:0] IDX_PER0_HI = 8'hd4;
  localparam logic [7:0] IDX_DUTY0_LO = 8'hd5;
  localparam logic [7:0] IDX_DUTY0_HI = 8'hd6;
  localparam logic [7:0] IDX_CTRL1 = 8'hd9;
  localparam logic [7:0] IDX_PER1 = 8'hda;
  localparam logic [7:0] IDX_DUTY1 = 8'hdb;
  localparam logic [7:0] IDX_CTRL2 = 8'hdd;
  localparam logic [7:0] IDX_PER2 = 8'hde;
  localparam logic [7:0] IDX_DUTY2 = 8'hdf;
  localparam logic [7:0] IDX_LOCK = 8'he7;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
  localparam logic [7:0] IDX_IRQ_GLOBAL = 8'hf2;
  localparam logic [NCH-1:0][7:0] CTRL_IDX = {IDX_CTRL2, IDX_CTRL1, IDX_CTRL0};
  localparam logic [NCH-1:0][7:0] CTRL_WMASK = {8'hc7, 8'hc7, 8'hdf};
  localparam int CTL_IE = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_FSTAT = 4;
  localparam int CTL_FLEVEL = 3;
  localparam int CTL_POL = 2;
  localparam int EN_FAULT = 6;
  localparam int EN_COMP_LO = 3;
  localparam int IRQ_FAULT = 3;
  localparam logic [7:0] LOCK_KEY = 8'h55;
  localparam logic [3:0][3:0] DIV_MASK = {4'hf, 4'h7, 4'h3, 4'h1};

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [6:0] enable;
    logic [7:0] lock;
    logic [NCH-1:0][7:0] ctrl;
    logic [CNT_W-1:0] per0;
    logic [CNT_W-1:0] duty0;
    logic [7:0] per1;
    logic [7:0] duty1;
    logic [7:0] per2;
    logic [7:0] duty2;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq_global;
    logic [3:0] div;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0][CNT_W-1:0] act_per;
    logic [NCH-1:0][CNT_W-1:0] act_duty;
    logic [NCH-1:0] act_pol;
    logic [NCH-1:0][1:0] act_sel;
    logic [NCH-1:0] pwm;
    logic [NCH-1:0] pwm_oe;
    logic [NCH-1:0] comp;
    logic [NCH-1:0] comp_oe;
    logic irq;
  } ptm_state_t;

  localparam ptm_state_t ST_RESET = '{waitreq: 1'b1, default: '0};
endpackage : ptm_pkg

// ---- hdl/ptm_timer.sv ----
// pwm timer: one 12-bit and two 8-bit channels, fault shutdown, write lock, avalon-mm slave
// assumes fault_input is synchronous to clk and the master holds each request until waitrequest is low
module ptm_timer
  import ptm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fault_input,
  output logic [NCH-1:0] pwm_out,
  output logic [NCH-1:0] pwm_oe,
  output logic [NCH-1:0] comp_out,
  output logic [NCH-1:0] comp_oe,
  output logic irq
);

  ptm_state_t q;
  ptm_state_t n;

  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] rd_value;
  logic commit;
  logic unlocked;
  logic cw;
  logic rdclr;
  logic fault_active;
  logic inactive;
  logic [NCH-1:0][CNT_W-1:0] cfg_per;
  logic [NCH-1:0][CNT_W-1:0] cfg_duty;
  logic [NCH-1:0] cfg_pol;
  logic [NCH-1:0][1:0] cfg_sel;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] run;
  logic [NCH-1:0] raw;
  logic [NCH-1:0] wrap;

  assign idx = avs_address[ADDR_W-1:2];
  assign wd = avs_writedata[7:0];
  // a write lands at the edge where the master sees waitrequest low
  assign commit = !q.waitreq && avs_write && avs_byteenable[0];
  assign unlocked = (q.lock == LOCK_KEY);
  assign cw = commit && unlocked;
  assign rdclr = !q.waitreq && avs_read && (idx == IDX_IRQ_STATUS);
  // fault pin is qualified by its enable and by the level select of channel 0 control
  assign fault_active = q.enable[EN_FAULT] && (fault_input == q.ctrl[0][CTL_FLEVEL]);
  // inactive covers the detection cycle as well as the held status
  assign inactive = q.ctrl[0][CTL_FSTAT] || fault_active;

  // 8-bit channels sit in the low bits of the common 12-bit counter path
  assign cfg_per = {{4'h0, q.per2}, {4'h0, q.per1}, q.per0};
  assign cfg_duty = {{4'h0, q.duty2}, {4'h0, q.duty1}, q.duty0};

  for (genvar g = 0; g < NCH; g++)
  begin : g_chan
    assign cfg_pol[g] = q.ctrl[g][CTL_POL];
    assign cfg_sel[g] = q.ctrl[g][1:0];
    // shared free-running divider; each channel takes its own tap
    assign tick[g] = &(q.div | ~DIV_MASK[q.act_sel[g]]);
  end

  always_comb
  begin
    case (idx)
      IDX_ENABLE: rd_value = {1'b0, q.enable};
      IDX_CTRL0: rd_value = q.ctrl[0];
      IDX_PER0_LO: rd_value = q.per0[7:0];
      IDX_PER0_HI: rd_value = {4'h0, q.per0[CNT_W-1:8]};
      IDX_DUTY0_LO: rd_value = q.duty0[7:0];
      IDX_DUTY0_HI: rd_value = {4'h0, q.duty0[CNT_W-1:8]};
      IDX_CTRL1: rd_value = q.ctrl[1];
      IDX_PER1: rd_value = q.per1;
      IDX_DUTY1: rd_value = q.duty1;
      IDX_CTRL2: rd_value = q.ctrl[2];
      IDX_PER2: rd_value = q.per2;
      IDX_DUTY2: rd_value = q.duty2;
      IDX_LOCK: rd_value = q.lock;
      IDX_IRQ_STATUS: rd_value = {4'h0, q.irq_status};
      IDX_IRQ_MASK: rd_value = {4'h0, q.irq_mask};
      IDX_IRQ_GLOBAL: rd_value = {7'h00, q.irq_global};
      default: rd_value = 8'h00;
    endcase
  end

  always_comb
  begin
    n = q;
    run = '0;
    raw = '0;
    wrap = '0;

    // bus handshake: one wait cycle, then a single cycle with waitrequest low
    n.waitreq = 1'b1;
    if (q.waitreq && (avs_read || avs_write))
    begin
      n.waitreq = 1'b0;
      n.rdata = {24'h000000, rd_value};
    end

    // the key register itself is never locked, otherwise software could never unlock
    if (commit)
    begin
      case (idx)
        IDX_LOCK: n.lock = wd;
        IDX_IRQ_MASK: n.irq_mask = wd[3:0];
        IDX_IRQ_GLOBAL: n.irq_global = wd[0];
        default: n.lock = q.lock;
      endcase
    end

    if (cw)
    begin
      case (idx)
        IDX_ENABLE: n.enable = wd[6:0];
        IDX_PER0_LO: n.per0[7:0] = wd;
        IDX_PER0_HI: n.per0[CNT_W-1:8] = wd[3:0];
        IDX_DUTY0_LO: n.duty0[7:0] = wd;
        IDX_DUTY0_HI: n.duty0[CNT_W-1:8] = wd[3:0];
        IDX_PER1: n.per1 = wd;
        IDX_DUTY1: n.duty1 = wd;
        IDX_PER2: n.per2 = wd;
        IDX_DUTY2: n.duty2 = wd;
        default: n.enable = q.enable;
      endcase
    end

    // control writes: flags can only be cleared by software, never set
    for (int i = 0; i < NCH; i++)
    begin
      if (cw && (idx == CTRL_IDX[i]))
      begin
        n.ctrl[i] = wd & CTRL_WMASK[i];
        n.ctrl[i][CTL_OVF] = q.ctrl[i][CTL_OVF] && wd[CTL_OVF];
      end
    end
    if (cw && (idx == IDX_CTRL0))
    begin
      n.ctrl[0][CTL_FSTAT] = q.ctrl[0][CTL_FSTAT] && wd[CTL_FSTAT];
    end

    // sticky fault status; a clear while the pin is still active is overridden
    if (fault_active)
    begin
      n.ctrl[0][CTL_FSTAT] = 1'b1;
    end

    if (rdclr)
    begin
      n.irq_status = 4'h0;
    end
    if (fault_active && !q.ctrl[0][CTL_FSTAT])
    begin
      n.irq_status[IRQ_FAULT] = 1'b1;
    end

    n.div = q.div + 4'h1;

    for (int i = 0; i < NCH; i++)
    begin
      // complementary output keeps the counter alive even if the main pin is off
      run[i] = q.enable[i] || q.enable[EN_COMP_LO + i];
      if (!run[i])
      begin
        n.cnt[i] = '0;
        n.act_per[i] = cfg_per[i];
        n.act_duty[i] = cfg_duty[i];
        n.act_pol[i] = cfg_pol[i];
        n.act_sel[i] = cfg_sel[i];
      end
      else if (tick[i])
      begin
        if ((q.act_per[i] == '0) || (q.cnt[i] >= q.act_per[i] - 12'h001))
        begin
          wrap[i] = 1'b1;
          n.cnt[i] = '0;
          // while running, reload only at the period boundary so a half-written value never glitches a cycle
          n.act_per[i] = cfg_per[i];
          n.act_duty[i] = cfg_duty[i];
          n.act_pol[i] = cfg_pol[i];
          n.act_sel[i] = cfg_sel[i];
        end
        else
        begin
          n.cnt[i] = q.cnt[i] + 12'h001;
        end
      end

      // hardware set wins over a software clear in the same cycle
      if (wrap[i] && (q.act_per[i] != '0))
      begin
        n.ctrl[i][CTL_OVF] = 1'b1;
        n.irq_status[i] = 1'b1;
      end

      // duty phase first; period at or below duty stays active, zero period never is
      raw[i] = (q.act_per[i] != '0) && (q.cnt[i] < q.act_duty[i]);
      if (inactive || !q.enable[i])
      begin
        n.pwm[i] = q.act_pol[i];
      end
      else
      begin
        n.pwm[i] = raw[i] ^ q.act_pol[i];
      end
      // no dead time here: the complement is a plain inversion of the active phase
      if (inactive || !q.enable[EN_COMP_LO + i])
      begin
        n.comp[i] = q.act_pol[i];
      end
      else
      begin
        n.comp[i] = ~(raw[i] ^ q.act_pol[i]);
      end
      n.pwm_oe[i] = q.enable[i];
      n.comp_oe[i] = q.enable[EN_COMP_LO + i];
    end

    // channel enables gate the overflow sources; the global bit gates everything
    n.irq = q.irq_global
      && |(q.irq_status & q.irq_mask & {1'b1, q.ctrl[2][CTL_IE], q.ctrl[1][CTL_IE], q.ctrl[0][CTL_IE]});
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= ST_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign pwm_out = q.pwm;
  assign pwm_oe = q.pwm_oe;
  assign comp_out = q.comp;
  assign comp_oe = q.comp_oe;
  assign irq = q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_fault_seen;
    fault_active;
  endsequence

  sequence s_locked_per_write;
    commit && !unlocked && (idx == IDX_PER0_LO);
  endsequence

  sequence s_div2_tick;
    !tick[0] ##1 tick[0];
  endsequence

  sequence s_ch1_overflow;
    wrap[1] && (q.act_per[1] != '0);
  endsequence

  a_fault_forces_inactive: assert property (
    s_fault_seen |=> (pwm_out == $past(q.act_pol)) && (comp_out == $past(q.act_pol)))
    else $error("outputs not inactive after fault");

  a_fault_status_set: assert property (
    s_fault_seen |=> q.ctrl[0][CTL_FSTAT] ##1 $past(q.ctrl[0][CTL_FSTAT]))
    else $error("fault status not set by fault");

  a_fault_clear_blocked: assert property (
    (fault_active && cw && (idx == IDX_CTRL0) && !wd[CTL_FSTAT]) |=> q.ctrl[0][CTL_FSTAT])
    else $error("fault status cleared while fault active");

  a_fault_needs_enable: assert property (
    (!q.enable[EN_FAULT] && !q.ctrl[0][CTL_FSTAT]) |=> !q.ctrl[0][CTL_FSTAT] || $past(cw))
    else $error("fault status set with fault input disabled");

  a_lock_blocks_write: assert property (
    s_locked_per_write |=> $stable(q.per0))
    else $error("period changed while locked");

  a_zero_period_level: assert property (
    (q.act_per[0] == '0) && q.enable[0] && !inactive |=> pwm_out[0] == $past(q.act_pol[0]))
    else $error("zero period output not at polarity level");

  a_full_duty_level: assert property (
    (q.act_per[0] != '0) && (q.act_duty[0] >= q.act_per[0]) && q.enable[0] && !inactive
      |=> pwm_out[0] == !$past(q.act_pol[0]))
    else $error("full duty output not active");

  a_reload_boundary: assert property (
    $changed(q.act_per[0]) |-> $past(wrap[0] || !run[0]))
    else $error("period reloaded mid period");

  a_prescale_div2: assert property (
    tick[0] && (q.act_sel[0] == 2'h0) && (cfg_sel[0] == 2'h0) |=> s_div2_tick)
    else $error("divide by two tick spacing wrong");

  a_overflow_flag: assert property (
    s_ch1_overflow |=> q.ctrl[1][CTL_OVF] && q.irq_status[1])
    else $error("overflow flag not raised at restart");

  a_flag_sw_clear: assert property (
    $fell(q.ctrl[1][CTL_OVF]) |-> $past(cw && (idx == IDX_CTRL1)))
    else $error("overflow flag cleared without software write");

  a_count_on_tick: assert property (
    $changed(q.cnt[0]) |-> $past(tick[0] || !run[0]))
    else $error("counter moved without pwm clock");

  a_irq_gated: assert property (
    irq |-> $past(q.irq_global) && ($past(q.irq_status & q.irq_mask) != 4'h0))
    else $error("interrupt without global enable or unmasked status");

endmodule : ptm_timer

// ---- tb/ptm_power_stage.sv ----
// stand-in for the power switches on the pwm pins: only their fault pin is modelled
// assumes the bench changes trip just after a rising clock edge
module ptm_power_stage
(
  input wire logic trip,
  input wire logic trip_level,
  output logic fault_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // the pin has no pull, so the quiet level is driven as the inverse of the active one
  assign fault_input = trip ? trip_level : ~trip_level;
endmodule : ptm_power_stage

// ---- tb/pwm_timer_12b_8b_fault_tb_top.sv ----
// self-checking bench for the pwm timer: register bus, waveforms, fault shutdown, interrupt
// assumes the power stage stand-in drives the fault pin and a single 100 MHz clock
module pwm_timer_12b_8b_fault_tb_top
  import ptm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REGS [6] = '{IDX_PER0_LO, IDX_PER0_HI, IDX_DUTY0_LO, IDX_DUTY0_HI, IDX_CTRL1, IDX_CTRL2};
  localparam logic [7:0] PER_IDX [3] = '{IDX_PER0_LO, IDX_PER1, IDX_PER2};
  localparam logic [7:0] DUTY_IDX [3] = '{IDX_DUTY0_LO, IDX_DUTY1, IDX_DUTY2};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic fault_input;
  logic [NCH-1:0] pwm_out;
  logic [NCH-1:0] pwm_oe;
  logic [NCH-1:0] comp_out;
  logic [NCH-1:0] comp_oe;
  logic irq;
  logic trip = 1'b0;
  logic trip_level = 1'b1;
  logic [31:0] expq [$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int per;
  int dty;

  always #5 clk = ~clk;

  ptm_timer i_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_input(fault_input),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .comp_out(comp_out), .comp_oe(comp_oe), .irq(irq));

  ptm_power_stage i_power (.trip(trip), .trip_level(trip_level), .fault_input(fault_input));

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one access; a read queues its expected byte for the watcher below
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] val);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, val};
    if (!wr)
      expq.push_back({24'h0, val});
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // idle edge so the next request never lands in the release time step
    @(posedge clk);
  endtask : bus

  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata, expq.pop_front());

  // counts high cycles of pwm_out[s], or of irq for s == 3
  task automatic meas(input int s, input int len, input int exp);
    int hi;
    logic v;
    hi = 0;
    repeat (len)
    begin
      @(posedge clk);
      v = (s == 3) ? irq : pwm_out[s];
      if (v === 1'b1)
        hi++;
    end
    check(hi, exp);
  endtask : meas

  // channel off first so the shadows follow the new values at once
  task automatic cfg(input int ch, input logic [11:0] p, input logic [11:0] d, input logic [7:0] ctl,
    input logic [7:0] en);
    bus(1'b1, IDX_ENABLE, 8'h00);
    bus(1'b1, PER_IDX[ch], p[7:0]);
    if (ch == 0)
      bus(1'b1, IDX_PER0_HI, {4'h0, p[11:8]});
    bus(1'b1, DUTY_IDX[ch], d[7:0]);
    if (ch == 0)
      bus(1'b1, IDX_DUTY0_HI, {4'h0, d[11:8]});
    bus(1'b1, CTRL_IDX[ch], ctl);
    bus(1'b1, IDX_ENABLE, en);
  endtask : cfg

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(33084));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (REGS[i])
    begin
      bus(1'b1, REGS[i], 8'hff);
      bus(1'b0, REGS[i], 8'h00);
    end
    bus(1'b0, 8'h10, 8'h00);
    bus(1'b1, IDX_LOCK, LOCK_KEY);
    for (int s = 0; s < 4; s++)
    begin
      per = $urandom_range(9, 3);
      dty = $urandom_range(per - 1, 1);
      cfg(0, 12'(per), 12'(dty), 8'(s), 8'h01);
      repeat (per * (2 << s) + 8) @(posedge clk);
      meas(0, 4 * per * (2 << s), 4 * dty * (2 << s));
      bus(1'b0, IDX_CTRL0, 8'h40 | 8'(s));
    end
    cfg(0, 12'h102, 12'h081, 8'h00, 8'h01);
    repeat (530) @(posedge clk);
    meas(0, 516, 258);
    cfg(0, 12'h006, 12'h002, 8'h04, 8'h01);
    repeat (20) @(posedge clk);
    meas(0, 48, 32);
    cfg(0, 12'h000, 12'h005, 8'h04, 8'h01);
    repeat (4) @(posedge clk);
    meas(0, 40, 40);
    cfg(0, 12'h003, 12'h005, 8'h00, 8'h01);
    repeat (16) @(posedge clk);
    meas(0, 40, 40);
    // channel 0 stays stopped here so its overflow flag cannot creep into the control reads
    cfg(1, 12'h004, 12'h003, 8'h00, 8'h02);
    bus(1'b1, IDX_CTRL0, 8'h0c);
    trip <= 1'b1;
    repeat (8) @(posedge clk);
    meas(1, 32, 24);
    bus(1'b1, IDX_ENABLE, 8'h42);
    repeat (2) @(posedge clk);
    check({comp_out[0], pwm_out}, 32'h9);
    meas(1, 40, 0);
    bus(1'b0, IDX_CTRL0, 8'h1c);
    bus(1'b1, IDX_CTRL0, 8'h0c);
    bus(1'b0, IDX_CTRL0, 8'h1c);
    trip <= 1'b0;
    meas(1, 32, 0);
    bus(1'b1, IDX_CTRL0, 8'h0c);
    bus(1'b0, IDX_CTRL0, 8'h0c);
    repeat (8) @(posedge clk);
    meas(1, 32, 24);
    bus(1'b1, IDX_IRQ_MASK, 8'h02);
    bus(1'b1, IDX_CTRL1, 8'h80);
    repeat (12) @(posedge clk);
    meas(3, 20, 0);
    bus(1'b1, IDX_IRQ_GLOBAL, 8'h01);
    repeat (2) @(posedge clk);
    meas(3, 20, 20);
    bus(1'b1, IDX_CTRL1, 8'h00);
    repeat (2) @(posedge clk);
    meas(3, 20, 0);
    bus(1'b1, IDX_ENABLE, 8'h00);
    bus(1'b0, IDX_IRQ_STATUS, 8'h0b);
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    bus(1'b1, IDX_LOCK, 8'h00);
    bus(1'b1, IDX_PER1, 8'h77);
    bus(1'b0, IDX_PER1, 8'h04);
    tally_and_finish();
  end
endmodule : pwm_timer_12b_8b_fault_tb_top
